/* hdl/ddrd_pkg.sv */
package ddrd_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] REG_STATUS = 5'h00;
  localparam logic [4:0] REG_MR0 = 5'h04;
  localparam logic [4:0] REG_MR1 = 5'h08;
  localparam logic [4:0] REG_MR2 = 5'h0C;
  localparam logic [4:0] REG_MR3 = 5'h10;
  localparam logic [4:0] REG_BURST = 5'h14;
  localparam logic [4:0] REG_DLLK = 5'h18;
  localparam logic [4:0] REG_ERR = 5'h1C;

  // Mode register select codes on the bank address pins
  localparam logic [2:0] MR_SEL_MR0 = 3'h0;
  localparam logic [2:0] MR_SEL_MR1 = 3'h1;
  localparam logic [2:0] MR_SEL_MR2 = 3'h2;
  localparam logic [2:0] MR_SEL_MR3 = 3'h3;

  // Mode register field positions
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_BT_BIT = 3;
  localparam int MR0_DLL_RST_BIT = 8;
  localparam int MR1_DLL_DIS_BIT = 0;
  localparam int MR1_RTT_A2 = 2;
  localparam int MR1_RTT_A6 = 6;
  localparam int MR1_RTT_A9 = 9;
  localparam int COL_BC_BIT = 12;

  // Burst length field codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  localparam logic [15:0] DLLK_DEFAULT = 16'h0200;
  localparam logic [14:0] MR_RESET_VAL = 15'h0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    DDRD_ST_RESET,
    DDRD_ST_WAIT_CKE,
    DDRD_ST_ACTIVE
  } ddrd_state_t;

  // Command and address pins as sampled on one clock crossing
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [2:0] ba;
    logic [14:0] addr;
  } ddrd_cmd_t;

  // Column order of one burst and the beats that carry data
  typedef struct packed {
    logic [7:0] active;
    logic [23:0] order;
  } ddrd_burst_t;

endpackage

/* hdl/ddrd_burst_order.sv */
`timescale 1ns/10ps
`default_nettype none
module ddrd_burst_order import ddrd_pkg::*; (
  input wire logic [2:0] start_col_in,
  input wire logic interleaved_in,
  input wire logic chop_in,
  input wire logic is_write_in,
  output ddrd_burst_t burst_out
);

  // One column index per beat; writes ignore the low start bits
  for (genvar i = 0; i < 8; i++) begin : g_beat
    localparam logic [2:0] BEAT = 3'(i);
    logic [2:0] col;
    always_comb begin
      if (is_write_in) begin
        col = chop_in ? {start_col_in[2], BEAT[1:0]} : BEAT; // RULE_23
      end else if (interleaved_in) begin
        col = start_col_in ^ BEAT; // RULE_22
      end else begin
        col = {start_col_in[2] ^ BEAT[2], 2'(start_col_in[1:0] + BEAT[1:0])}; // RULE_22
      end
    end
    assign burst_out.order[3*i +: 3] = col;
    // Chopped bursts carry only the first four beats
    assign burst_out.active[i] = !chop_in || (i < 4); // RULE_23
  end

endmodule
`default_nettype wire

/* hdl/ddrd_top.sv */
// Functional notes
// [RULE_01] Controller waits 500 us after reset release before raising CKE.
// [RULE_02] Clock runs stable for max of 10 ns or 5 periods before CKE.
// [RULE_03] A NOP or deselect is registered before CKE goes high.
// [RULE_04] CKE stays high from first registration until initialization ends.
// [RULE_05] Termination stays off in reset and until CKE is first registered high.
// [RULE_06] Controller holds ODT static during init, low if nominal termination enabled.
// [RULE_07] Controller waits tXPR after CKE high before the first mode register load.
// [RULE_08] Load order is MR2, MR3, MR1 with DLL on, then MR0 with DLL reset.
// [RULE_09] Bank address bits pick the mode register, 0 to 3.
// [RULE_10] MR1 bit 0 low enables the DLL; MR0 bit 8 high resets it.
// [RULE_11] Long ZQ calibration follows MR0; wait DLL lock and ZQ init.
// [RULE_12] Warm reset: reset low 100 ns, CKE low 10 ns, then redo sequence.
// [RULE_13] Mode registers are undefined after reset until fully written.
// [RULE_14] Each mode register load supplies every field.
// [RULE_15] Mode register loads and DLL resets leave the array untouched.
// [RULE_16] Successive mode register loads are spaced by tMRD.
// [RULE_17] Only NOP, deselect or load follow a load within tMOD.
// [RULE_18] Mode registers are rewritten in normal operation only when idle.
// [RULE_19] Load command is CS, RAS, CAS, WE all low; opcode on address.
// [RULE_20] MR0 bit 3 picks sequential or interleaved burst order.
// [RULE_21] MR0 bits 1:0 pick chop-4, 8, or on-the-fly via column bit 12.
// [RULE_22] Read order wraps sequentially in a half, or start XOR beat.
// [RULE_23] Chopped reads drive four beats; chopped writes use column half by bit 2.
// [RULE_24] DLL reset bit self-clears; reads wait tDLLK after a DLL reset.
// [RULE_25] Controller times its waits with configurable cycle counters.
`timescale 1ns/10ps
`default_nettype none
module ddrd_top import ddrd_pkg::*; #(
  parameter logic [15:0] DLLK_CYCLES = DLLK_DEFAULT
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic mem_reset_n_in,
  input wire logic mem_ck_in,
  input wire logic mem_cke_in,
  input wire logic mem_cs_n_in,
  input wire logic mem_ras_n_in,
  input wire logic mem_cas_n_in,
  input wire logic mem_we_n_in,
  input wire logic [2:0] mem_ba_in,
  input wire logic [14:0] mem_addr_in,
  input wire logic mem_odt_in,
  output logic term_en_out,
  output logic dll_locked_out,
  output logic init_done_out
);

  if (DLLK_CYCLES == 16'h0000) begin : g_chk
    $error("DLLK_CYCLES must be at least one");
  end

  ddrd_cmd_t pin_now, cmd_s1_reg, cmd_s2_reg;
  logic rstn_s1_reg, rstn_s2_reg;
  logic [2:0] ck_sync_reg;
  ddrd_state_t state_reg;
  logic [14:0] mr_reg [4];
  logic [3:0] mr_valid_reg;
  logic [15:0] dllk_cfg_reg, dllk_cnt_reg;
  logic dll_locked_reg, term_en_reg, init_done_reg;
  logic [1:0] err_reg;
  logic [31:0] burst_reg, readdata_reg;
  logic waitreq_reg;
  ddrd_burst_t burst_calc;
  logic ck_rise, cmd_valid, is_mrs, is_rdwr, chop;
  logic bus_req, bus_grant;

  assign pin_now = '{cke: mem_cke_in, cs_n: mem_cs_n_in, ras_n: mem_ras_n_in,
                     cas_n: mem_cas_n_in, we_n: mem_we_n_in, odt: mem_odt_in,
                     ba: mem_ba_in, addr: mem_addr_in};

  // Two-stage synchronisers for every pin, three stages for CK
  always_ff @(posedge sys_clk_in) begin
    cmd_s1_reg <= pin_now;
    cmd_s2_reg <= cmd_s1_reg;
    rstn_s1_reg <= mem_reset_n_in;
    rstn_s2_reg <= rstn_s1_reg;
    ck_sync_reg <= {ck_sync_reg[1:0], mem_ck_in};
  end

  // Edge taken from the second and third stages only
  assign ck_rise = ck_sync_reg[1] && !ck_sync_reg[2];
  assign cmd_valid = ck_rise && state_reg == DDRD_ST_ACTIVE && cmd_s2_reg.cke &&
                     !cmd_s2_reg.cs_n;
  assign is_mrs = cmd_valid && !cmd_s2_reg.ras_n && !cmd_s2_reg.cas_n &&
                  !cmd_s2_reg.we_n; // RULE_19
  assign is_rdwr = cmd_valid && cmd_s2_reg.ras_n && !cmd_s2_reg.cas_n;

  // Power-up sequencing; the reset pin restarts it from any state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !rstn_s2_reg) begin
      state_reg <= DDRD_ST_RESET;
    end else begin
      case (state_reg)
        DDRD_ST_RESET: state_reg <= DDRD_ST_WAIT_CKE;
        DDRD_ST_WAIT_CKE: begin
          if (ck_rise && cmd_s2_reg.cke) begin
            state_reg <= DDRD_ST_ACTIVE;
          end
        end
        DDRD_ST_ACTIVE: state_reg <= DDRD_ST_ACTIVE;
        default: state_reg <= DDRD_ST_RESET;
      endcase
    end
  end

  // Termination only once CKE has been seen high after reset
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !rstn_s2_reg) begin
      term_en_reg <= 1'b0; // RULE_05
    end else if (state_reg != DDRD_ST_ACTIVE) begin
      term_en_reg <= 1'b0; // RULE_05
    end else if (ck_rise) begin
      term_en_reg <= cmd_s2_reg.odt &&
                     (mr_reg[1][MR1_RTT_A2] || mr_reg[1][MR1_RTT_A6] || mr_reg[1][MR1_RTT_A9]);
    end
  end

  // Mode registers; loads touch only these, never array contents
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !rstn_s2_reg) begin
      for (int i = 0; i < 4; i++) begin
        mr_reg[i] <= MR_RESET_VAL;
      end
      mr_valid_reg <= 4'h0;
    end else begin
      if (is_mrs && !cmd_s2_reg.ba[2]) begin
        mr_reg[cmd_s2_reg.ba[1:0]] <= cmd_s2_reg.addr; // RULE_09
        mr_valid_reg[cmd_s2_reg.ba[1:0]] <= 1'b1; // RULE_15
      end else if (mr_reg[0][MR0_DLL_RST_BIT]) begin
        mr_reg[0][MR0_DLL_RST_BIT] <= 1'b0; // RULE_24
      end
    end
  end

  // DLL lock timer, counted in CK edges; needs the DLL enabled in MR1
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !rstn_s2_reg) begin
      dllk_cnt_reg <= 16'h0000;
      dll_locked_reg <= 1'b0;
    end else if (is_mrs && cmd_s2_reg.ba == MR_SEL_MR0 && cmd_s2_reg.addr[MR0_DLL_RST_BIT]) begin
      dllk_cnt_reg <= 16'h0000; // RULE_10
      dll_locked_reg <= 1'b0; // RULE_24
    end else if (is_mrs && cmd_s2_reg.ba == MR_SEL_MR1 && cmd_s2_reg.addr[MR1_DLL_DIS_BIT]) begin
      dll_locked_reg <= 1'b0; // RULE_10
    end else if (ck_rise && !mr_reg[1][MR1_DLL_DIS_BIT] && mr_valid_reg[0] && !dll_locked_reg) begin
      dllk_cnt_reg <= dllk_cnt_reg + 16'h0001;
      dll_locked_reg <= (dllk_cnt_reg + 16'h0001) >= dllk_cfg_reg; // RULE_24
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      init_done_reg <= 1'b0;
    end else begin
      init_done_reg <= state_reg == DDRD_ST_ACTIVE && (&mr_valid_reg) && dll_locked_reg; // RULE_13
    end
  end

  // Burst length: fixed chop, fixed eight, or column bit 12 on the fly
  always_comb begin
    case (mr_reg[0][MR0_BL_LSB +: 2])
      BL_FIXED4: chop = 1'b1; // RULE_21
      BL_OTF: chop = !cmd_s2_reg.addr[COL_BC_BIT]; // RULE_21
      default: chop = 1'b0;
    endcase
  end

  ddrd_burst_order u_order (
    .start_col_in(cmd_s2_reg.addr[2:0]),
    .interleaved_in(mr_reg[0][MR0_BT_BIT]), // RULE_20
    .chop_in(chop),
    .is_write_in(!cmd_s2_reg.we_n),
    .burst_out(burst_calc)
  );

  // Latest burst plan, held for software to inspect
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      burst_reg <= READ_ZERO;
    end else if (is_rdwr) begin
      burst_reg <= burst_calc; // RULE_22
    end
  end

  // Avalon slave: one wait cycle per request, then a one-cycle grant
  assign bus_req = avs_read_in || avs_write_in;
  assign bus_grant = bus_req && !waitreq_reg;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      waitreq_reg <= 1'b1;
    end else begin
      waitreq_reg <= !(bus_req && waitreq_reg);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dllk_cfg_reg <= DLLK_CYCLES;
    end else if (bus_grant && avs_write_in && avs_address_in == REG_DLLK) begin
      dllk_cfg_reg <= (avs_writedata_in[15:0] == 16'h0000) ? 16'h0001 : avs_writedata_in[15:0];
    end
  end

  // Sticky faults: early read, bad mode register select; set beats clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      err_reg <= 2'h0;
    end else begin
      err_reg <= (err_reg & ~((bus_grant && avs_write_in && avs_address_in == REG_ERR) ?
                             avs_writedata_in[1:0] : 2'h0)) |
                 {is_mrs && cmd_s2_reg.ba[2], is_rdwr && cmd_s2_reg.we_n && !dll_locked_reg};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      readdata_reg <= READ_ZERO;
    end else if (bus_req && waitreq_reg) begin
      case (avs_address_in)
        REG_STATUS: readdata_reg <= 32'({init_done_reg, dll_locked_reg, term_en_reg,
                                         mr_valid_reg, state_reg});
        REG_MR0: readdata_reg <= 32'(mr_reg[0]);
        REG_MR1: readdata_reg <= 32'(mr_reg[1]);
        REG_MR2: readdata_reg <= 32'(mr_reg[2]);
        REG_MR3: readdata_reg <= 32'(mr_reg[3]);
        REG_BURST: readdata_reg <= burst_reg;
        REG_DLLK: readdata_reg <= 32'(dllk_cfg_reg);
        REG_ERR: readdata_reg <= 32'(err_reg);
        default: readdata_reg <= READ_ZERO;
      endcase
    end
  end

  assign avs_readdata_out = readdata_reg;
  assign avs_waitrequest_out = waitreq_reg;
  assign term_en_out = term_en_reg;
  assign dll_locked_out = dll_locked_reg;
  assign init_done_out = init_done_reg;

  property p_term_off_early;
    @(posedge sys_clk_in) disable iff (rst_in)
      state_reg != DDRD_ST_ACTIVE |=> !term_en_reg;
  endproperty
  a_term_off_early: assert property (p_term_off_early) else $error("termination on before CKE"); // RULE_05

  property p_mrs_select;
    @(posedge sys_clk_in) disable iff (rst_in || !rstn_s2_reg)
      is_mrs && cmd_s2_reg.ba == MR_SEL_MR2 |=> mr_reg[2] == $past(cmd_s2_reg.addr) && mr_valid_reg[2];
  endproperty
  a_mrs_select: assert property (p_mrs_select) else $error("MR2 load lost"); // RULE_09

  property p_dll_selfclear;
    @(posedge sys_clk_in) disable iff (rst_in || !rstn_s2_reg)
      $rose(mr_reg[0][MR0_DLL_RST_BIT]) ##1 !is_mrs |-> !mr_reg[0][MR0_DLL_RST_BIT];
  endproperty
  a_dll_selfclear: assert property (p_dll_selfclear) else $error("DLL reset bit stuck"); // RULE_24

  property p_dll_relock;
    @(posedge sys_clk_in) disable iff (rst_in || !rstn_s2_reg)
      is_mrs && cmd_s2_reg.ba == MR_SEL_MR0 && cmd_s2_reg.addr[MR0_DLL_RST_BIT]
      |=> !dll_locked_reg ##1 !dll_locked_reg;
  endproperty
  a_dll_relock: assert property (p_dll_relock) else $error("DLL lock kept across reset"); // RULE_24

  property p_dll_disable;
    @(posedge sys_clk_in) disable iff (rst_in || !rstn_s2_reg)
      is_mrs && cmd_s2_reg.ba == MR_SEL_MR1 && cmd_s2_reg.addr[MR1_DLL_DIS_BIT] |=> !dll_locked_reg;
  endproperty
  a_dll_disable: assert property (p_dll_disable) else $error("DLL locked while disabled"); // RULE_10

  property p_chop_beats;
    @(posedge sys_clk_in) disable iff (rst_in)
      is_rdwr && chop |=> burst_reg[31:24] == 8'h0F;
  endproperty
  a_chop_beats: assert property (p_chop_beats) else $error("chopped burst drives late beats"); // RULE_23

  property p_interleave;
    @(posedge sys_clk_in) disable iff (rst_in)
      is_rdwr && cmd_s2_reg.we_n && mr_reg[0][MR0_BT_BIT]
      |=> burst_reg[5:3] == ($past(cmd_s2_reg.addr[2:0]) ^ 3'h1);
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleaved beat one wrong"); // RULE_20

  property p_otf_chop;
    @(posedge sys_clk_in) disable iff (rst_in)
      is_rdwr && mr_reg[0][1:0] == BL_OTF && cmd_s2_reg.addr[COL_BC_BIT]
      |=> burst_reg[31:24] == 8'hFF;
  endproperty
  a_otf_chop: assert property (p_otf_chop) else $error("on-the-fly burst of eight chopped"); // RULE_21

  property p_seq_wrap;
    @(posedge sys_clk_in) disable iff (rst_in)
      is_rdwr && cmd_s2_reg.we_n && !mr_reg[0][MR0_BT_BIT] && cmd_s2_reg.addr[1:0] == 2'h3
      |=> burst_reg[5:3] == {burst_reg[2], 2'h0};
  endproperty
  a_seq_wrap: assert property (p_seq_wrap) else $error("sequential wrap wrong"); // RULE_22

endmodule
`default_nettype wire

/* test/ddrd_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ddrd_ctrl_model import ddrd_pkg::*; #(
  parameter int INIT_CK = 20,
  parameter int XPR_CK = 5,
  parameter int MRD_CK = 4
) (
  output logic ck_out,
  output logic reset_n_out,
  output var ddrd_cmd_t cmd_out
);
  // Memory clock runs free once powered, as the wake-up needs it stable
  initial ck_out = 1'b0;
  always #24 ck_out = ~ck_out;

  // Power-up state: reset held, CKE low, deselected
  initial begin
    reset_n_out = 1'b0;
    cmd_out = {6'h1E, 18'h0_0000};
  end

  task automatic idle(input int n);
    repeat (n) @(negedge ck_out);
  endtask

  // Pins change half a period before the rise, so they are stable well past sampling
  task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic [14:0] a);
    @(negedge ck_out);
    {cmd_out.cs_n, cmd_out.ras_n, cmd_out.cas_n, cmd_out.we_n} <= c;
    cmd_out.ba <= ba;
    cmd_out.addr <= a;
    @(negedge ck_out);
    cmd_out.cs_n <= 1'b1;
    cmd_out.addr <= ~a; // Deselected address and bank lines never keep the last value
    cmd_out.ba <= ~ba;
  endtask

  task automatic mrs(input logic [2:0] ba, input logic [14:0] a);
    issue(4'h0, ba, a);
    idle(MRD_CK);
  endtask

  // Reset pulse with CKE already low, used for cold and warm starts
  task automatic rst_pulse;
    cmd_out.cke <= 1'b0;
    idle(1);
    reset_n_out <= 1'b0;
    idle(3);
    reset_n_out <= 1'b1;
    // Let the release pass the pin synchroniser before anyone looks at status
    idle(1);
  endtask

  // Scaled wait keeps run time short; deselects are registered all along
  task automatic wake;
    idle(INIT_CK);
    cmd_out.odt <= 1'b0;
    cmd_out.cke <= 1'b1;
    idle(XPR_CK);
  endtask

  // Load order fixed: MR2, MR3, MR1, MR0, then long calibration
  task automatic init(input logic [14:0] m0, input logic [14:0] m1, input int dllk);
    mrs(MR_SEL_MR2, 15'h0008);
    mrs(MR_SEL_MR3, 15'h0004);
    mrs(MR_SEL_MR1, m1);
    mrs(MR_SEL_MR0, m0);
    issue(4'h6, 3'h0, 15'h0400);
    idle(dllk + 4);
  endtask

  task automatic odt(input logic v);
    @(negedge ck_out);
    cmd_out.odt <= v;
    idle(2);
  endtask
endmodule
`default_nettype wire

/* test/ddrd_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ddrd_top_tb import ddrd_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rq, rdat;
  logic wq, ck, rn, term, dll, done;
  ddrd_cmd_t cmd;
  int fails = 0;
  int total_checks = 0;

  always #2 clk = ~clk;

  ddrd_ctrl_model u_mdl (.ck_out(ck), .reset_n_out(rn), .cmd_out(cmd));

  ddrd_top #(.DLLK_CYCLES(16'h0008)) dut_u (
    .sys_clk_in(clk), .rst_in(rst), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rq),
    .avs_waitrequest_out(wq), .mem_reset_n_in(rn), .mem_ck_in(ck),
    .mem_cke_in(cmd.cke), .mem_cs_n_in(cmd.cs_n), .mem_ras_n_in(cmd.ras_n),
    .mem_cas_n_in(cmd.cas_n), .mem_we_n_in(cmd.we_n), .mem_ba_in(cmd.ba),
    .mem_addr_in(cmd.addr), .mem_odt_in(cmd.odt), .term_en_out(term),
    .dll_locked_out(dll), .init_done_out(done));

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One bus transfer, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 100);
    if (n >= 100) fails++;
    rdat = rq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0000_0000);
    chk(nm, rdat, e);
  endtask

  // Column order per beat, three bits a beat, beat 0 lowest
  function automatic logic [31:0] burst(input logic [2:0] s, input logic bt,
                                        input logic ch, input logic w);
    logic [23:0] o;
    logic [2:0] i;
    for (int k = 0; k < 8; k++) begin
      i = k[2:0];
      if (w) o[3*k +: 3] = ch ? {s[2], i[1:0]} : i;
      else if (bt) o[3*k +: 3] = s ^ i;
      else o[3*k +: 3] = {s[2] ^ i[2], s[1:0] + i[1:0]};
    end
    return {ch ? 8'h0F : 8'hFF, o};
  endfunction

  task automatic t_reset;
    rdchk("status", REG_STATUS, 32'h0000_0000);
    chk("term", {31'h0000_0000, term}, 32'h0000_0000);
    rdchk("dllk", REG_DLLK, 32'h0000_0008);
    av(1'b1, REG_MR0, 32'h0000_7FFF);
    rdchk("mr0 ro", REG_MR0, 32'h0000_0000);
    av(1'b1, REG_DLLK, 32'h0000_0000);
    rdchk("dllk zero", REG_DLLK, 32'h0000_0001);
    av(1'b1, REG_DLLK, 32'h0000_0008);
    $display("test reset done");
  endtask

  // Loads before CKE are refused, then a full initialisation
  task automatic t_init;
    u_mdl.rst_pulse;
    rdchk("status wait", REG_STATUS, 32'h0000_0001);
    u_mdl.mrs(MR_SEL_MR2, 15'h0055);
    rdchk("mr2 early", REG_MR2, 32'h0000_0000);
    u_mdl.wake;
    u_mdl.init(15'h0100, 15'h0004, 8);
    rdchk("status done", REG_STATUS, 32'h0000_01BE);
    rdchk("mr0", REG_MR0, 32'h0000_0000);
    rdchk("mr1", REG_MR1, 32'h0000_0004);
    rdchk("mr2", REG_MR2, 32'h0000_0008);
    rdchk("mr3", REG_MR3, 32'h0000_0004);
    chk("flags", {29'h0000_0000, done, dll, term}, 32'h0000_0006);
    $display("test init done");
  endtask

  task automatic t_odt;
    u_mdl.odt(1'b1);
    chk("term on", {31'h0000_0000, term}, 32'h0000_0001);
    rdchk("status term", REG_STATUS, 32'h0000_01FE);
    u_mdl.odt(1'b0);
    chk("term off", {31'h0000_0000, term}, 32'h0000_0000);
    $display("test odt done");
  endtask

  task automatic t_err;
    u_mdl.mrs(3'h4, 15'h7FFF);
    rdchk("err ba", REG_ERR, 32'h0000_0002);
    rdchk("mr0 kept", REG_MR0, 32'h0000_0000);
    av(1'b1, REG_ERR, 32'h0000_0002);
    rdchk("err clr", REG_ERR, 32'h0000_0000);
    rdchk("unmapped", 5'h1E, 32'h0000_0000);
    // DLL off drops the lock; re-enable and reset it, then wait for relock
    u_mdl.mrs(MR_SEL_MR1, 15'h0005);
    chk("dll off", {31'h0000_0000, dll}, 32'h0000_0000);
    u_mdl.mrs(MR_SEL_MR1, 15'h0004);
    u_mdl.mrs(MR_SEL_MR0, 15'h0100);
    chk("dll reset", {31'h0000_0000, dll}, 32'h0000_0000);
    u_mdl.idle(12);
    chk("dll relock", {31'h0000_0000, dll}, 32'h0000_0001);
    $display("test err done");
  endtask

  // Every length code and type, every start column, reads and writes
  task automatic t_burst;
    logic ch;
    logic [31:0] m;
    for (int bl = 0; bl < 3; bl++) begin
      for (int bt = 0; bt < 2; bt++) begin
        u_mdl.mrs(MR_SEL_MR0, {11'h000, bt[0], 1'b0, bl[1:0]});
        for (int s = 0; s < 16; s++) begin
          ch = (bl == 2) || (bl == 1 && !s[0]);
          m = ch ? 32'hFF00_0FFF : 32'hFFFF_FFFF;
          u_mdl.issue(s[3] ? 4'h4 : 4'h5, 3'h0, {2'h0, s[0], 9'h000, s[2:0]});
          av(1'b0, REG_BURST, 32'h0000_0000);
          chk("burst", rdat & m, burst(s[2:0], bt[0], ch, s[3]) & m);
        end
      end
    end
    $display("test burst done");
  endtask

  task automatic t_warm;
    u_mdl.rst_pulse;
    rdchk("status warm", REG_STATUS, 32'h0000_0001);
    rdchk("mr1 warm", REG_MR1, 32'h0000_0000);
    u_mdl.wake;
    // A read before the DLL has locked is flagged in the error register
    u_mdl.issue(4'h5, 3'h0, 15'h0000);
    rdchk("err early", REG_ERR, 32'h0000_0001);
    av(1'b1, REG_ERR, 32'h0000_0001);
    rdchk("err early clr", REG_ERR, 32'h0000_0000);
    u_mdl.init(15'h0100, 15'h0004, 8);
    rdchk("status again", REG_STATUS, 32'h0000_01BE);
    $display("test warm done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_init;
    t_odt;
    t_err;
    t_burst;
    t_warm;
    final_report;
  end

  // Cuts a hang short well beyond the expected run
  initial begin
    #300000;
    fails++;
    $display("watchdog expired");
    final_report;
  end
endmodule
`default_nettype wire
